/* File: rtl/smbus_cfg.svh */
// Purpose: Shared offsets-free constants for the two-wire bus interface.
// Assumes: System clock of 100 MHz.
// Notes:   Timing counts are in system clocks or bus clock source ticks.
`ifndef SMBUS_CFG_SVH
`define SMBUS_CFG_SVH

// Least system clocks per SCL phase: two phases per bit give a bit rate of clk/20.
`define SMB_MIN_PHASE_CYC 8'd10
// Bus clock source overflows per SCL phase; the second one guarantees a whole period.
`define SMB_PHASE_TICKS   2'd2
// Overflow periods with both lines high before the bus counts as free.
`define SMB_FREE_TICKS    4'd10
// System clocks SDA is held after SCL is pulled low before it may change.
`define SMB_SDA_HOLD_CYC  8'd3

`endif

/* File: rtl/smbus_if_core.sv */
// Purpose: Byte-wide master and slave engine for a shared open-drain two-wire bus.
// Assumes: bus_tick_i is a one-cycle pulse per overflow of the chosen timer.
// Notes:   SCL and SDA are sampled by two flip-flops before any logic looks at them.
`timescale 1ns/1ns
`include "smbus_cfg.svh"

module smbus_if_core #(
  parameter logic [7:0] MIN_PHASE_CYC = `SMB_MIN_PHASE_CYC
) (
  input  logic                 clk_i,
  input  logic                 arst_n_i,
  input  logic                 scl_i,
  input  logic                 sda_i,
  output logic                 scl_o,
  output logic                 scl_oe_o,
  output logic                 sda_o,
  output logic                 sda_oe_o,
  input  logic                 bus_tick_i,
  input  logic                 enable_i,
  input  logic                 slave_inhibit_i,
  input  logic                 hw_ack_en_i,
  input  logic                 free_to_en_i,
  input  logic                 slave_ack_i,
  input  logic [6:0]           own_addr_i,
  input  logic                 cmd_valid_i,
  input  smbus_pkg::cmd_op_t   cmd_op_i,
  input  logic [7:0]           cmd_data_i,
  input  logic                 cmd_ack_i,
  output logic                 cmd_ready_o,
  output logic                 rx_valid_o,
  output logic [7:0]           rx_data_o,
  input  logic                 rx_ready_i,
  output logic                 byte_done_o,
  output logic                 ack_o,
  output logic                 arb_lost_o,
  output logic                 stop_seen_o,
  output logic                 addressed_o,
  output logic                 master_o,
  output logic                 busy_o,
  output logic                 read_dir_o
);

  if (MIN_PHASE_CYC < `SMB_MIN_PHASE_CYC || MIN_PHASE_CYC <= `SMB_SDA_HOLD_CYC)
  begin : g_bad_phase
    $error("MIN_PHASE_CYC too small for the bit rate or the SDA hold time.");
  end

  smbus_pkg::state_t s;
  smbus_pkg::state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  ////////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    logic       start_det;
    logic       stop_det;
    logic       rise;
    logic       fall;
    logic       ph_done;
    logic       accept;
    logic       ackv;
    logic       push_v;
    logic [7:0] push_d;
    logic       restart;
    next_s    = s;
    push_v    = 1'b0;
    push_d    = s.shift;
    restart   = 1'b0;
    ackv      = 1'b0;
    next_s.ev_byte = 1'b0;
    next_s.ev_arb  = 1'b0;
    next_s.ev_stop = 1'b0;
    next_s.ev_addr = 1'b0;

    next_s.scl_m = scl_i;
    next_s.scl_s = s.scl_m;
    next_s.scl_q = s.scl_s;
    next_s.sda_m = sda_i;
    next_s.sda_s = s.sda_m;
    next_s.sda_q = s.sda_s;
    start_det = s.scl_s && s.scl_q && s.sda_q && !s.sda_s;
    stop_det  = s.scl_s && s.scl_q && !s.sda_q && s.sda_s;
    rise      = s.scl_s && !s.scl_q;
    fall      = !s.scl_s && s.scl_q;
    accept    = cmd_valid_i && s.cmd_ready;

    // Phase timer: system clocks and clock source overflows since phase entry.
    if (s.ph_cnt != 8'hff)
    begin
      next_s.ph_cnt = s.ph_cnt + 8'h01;
    end
    if (bus_tick_i && s.tick_cnt != `SMB_PHASE_TICKS)
    begin
      next_s.tick_cnt = s.tick_cnt + 2'h1;
    end
    ph_done = s.ph_cnt >= MIN_PHASE_CYC && s.tick_cnt == `SMB_PHASE_TICKS;

    // Bus busy tracking and free timeout.
    if (s.scl_s && s.sda_s)
    begin
      if (bus_tick_i && s.free_cnt <= `SMB_FREE_TICKS)
      begin
        next_s.free_cnt = s.free_cnt + 4'h1;
      end
    end
    else
    begin
      next_s.free_cnt = 4'h0;
    end
    if (start_det)
    begin
      next_s.busy = 1'b1;
    end
    else if (stop_det || (free_to_en_i && s.free_cnt > `SMB_FREE_TICKS))
    begin
      next_s.busy = 1'b0;
    end

    // Receive buffer drain.
    if (s.hd_v && rx_ready_i)
    begin
      next_s.hd_v = s.tl_v;
      next_s.hd_d = s.tl_d;
      next_s.tl_v = 1'b0;
    end

    unique case (s.state)
      smbus_pkg::ST_IDLE:
      begin
        next_s.scl_drv = 1'b0;
        next_s.sda_drv = 1'b0;
        if (accept && cmd_op_i == smbus_pkg::OP_START)
        begin
          next_s.shift   = cmd_data_i;
          next_s.addr_ph = 1'b1;
          next_s.is_read = 1'b0;
          next_s.state   = smbus_pkg::ST_WAIT_FREE;
        end
      end
      smbus_pkg::ST_WAIT_FREE:
      begin
        if (!s.busy)
        begin
          next_s.master = 1'b1;
          next_s.step   = 1'b0;
          next_s.state  = smbus_pkg::ST_M_START;
          restart       = 1'b1;
        end
      end
      smbus_pkg::ST_M_START:
      begin
        next_s.scl_drv = 1'b0;
        if (!s.step)
        begin
          next_s.sda_drv = 1'b0;
          if (!s.scl_s)
          begin
            restart = 1'b1;
          end
          else if (ph_done)
          begin
            next_s.sda_drv = 1'b1;
            next_s.step    = 1'b1;
            restart        = 1'b1;
          end
        end
        else if (ph_done)
        begin
          next_s.bit_idx = 4'h0;
          next_s.step    = 1'b0;
          next_s.state   = smbus_pkg::ST_M_LOW;
          next_s.scl_drv = 1'b1;
          restart        = 1'b1;
        end
      end
      smbus_pkg::ST_M_LOW:
      begin
        next_s.scl_drv = 1'b1;
        if (s.ph_cnt == `SMB_SDA_HOLD_CYC)
        begin
          if (s.bit_idx[3])
          begin
            next_s.sda_drv = s.is_read && s.mack;
          end
          else
          begin
            next_s.sda_drv = !s.is_read && !s.shift[7];
          end
        end
        if (ph_done)
        begin
          next_s.scl_drv = 1'b0;
          next_s.step    = 1'b0;
          next_s.state   = smbus_pkg::ST_M_HIGH;
          restart        = 1'b1;
        end
      end
      smbus_pkg::ST_M_HIGH:
      begin
        if (!s.step)
        begin
          restart = 1'b1;
          if (s.scl_s)
          begin
            next_s.step = 1'b1;
            next_s.samp = s.sda_s;
          end
        end
        else if (s.scl_s && !s.sda_s && !s.sda_drv && !s.bit_idx[3] && !s.is_read)
        begin
          next_s.master  = 1'b0;
          next_s.ev_arb  = 1'b1;
          next_s.scl_drv = 1'b0;
          next_s.shift   = {s.shift[6:0], 1'b0};
          next_s.state   = smbus_pkg::ST_S_RX;
          next_s.inh     = slave_inhibit_i;
        end
        else if (!s.scl_s || ph_done)
        begin
          next_s.scl_drv = 1'b1;
          next_s.step    = 1'b0;
          restart        = 1'b1;
          next_s.bit_idx = s.bit_idx + 4'h1;
          if (!s.bit_idx[3])
          begin
            next_s.shift = {s.shift[6:0], s.samp};
            next_s.state = smbus_pkg::ST_M_LOW;
          end
          else
          begin
            next_s.ack     = s.is_read ? s.mack : !s.samp;
            next_s.ev_byte = 1'b1;
            push_v         = s.is_read;
            next_s.addr_ph = 1'b0;
            next_s.state   = smbus_pkg::ST_M_HOLD;
          end
        end
        else
        begin
          next_s.samp = s.sda_s;
        end
      end
      smbus_pkg::ST_M_HOLD:
      begin
        next_s.scl_drv = 1'b1;
        if (s.ph_cnt == `SMB_SDA_HOLD_CYC)
        begin
          next_s.sda_drv = 1'b0;
        end
        if (!s.step && ph_done)
        begin
          next_s.step = 1'b1;
        end
        if (accept)
        begin
          next_s.step    = 1'b0;
          next_s.shift   = cmd_data_i;
          next_s.bit_idx = 4'h0;
          next_s.is_read = cmd_op_i == smbus_pkg::OP_READ;
          next_s.mack    = cmd_ack_i;
          restart        = 1'b1;
          if (cmd_op_i == smbus_pkg::OP_START)
          begin
            next_s.addr_ph = 1'b1;
            next_s.state   = smbus_pkg::ST_M_START;
          end
          else if (cmd_op_i == smbus_pkg::OP_STOP)
          begin
            next_s.state = smbus_pkg::ST_M_STOP;
          end
          else if (cmd_op_i != smbus_pkg::OP_SLV_DATA)
          begin
            next_s.state = smbus_pkg::ST_M_LOW;
          end
        end
      end
      smbus_pkg::ST_M_STOP:
      begin
        next_s.sda_drv = 1'b1;
        if (!s.step)
        begin
          next_s.scl_drv = 1'b1;
          if (ph_done)
          begin
            next_s.scl_drv = 1'b0;
            next_s.step    = 1'b1;
            restart        = 1'b1;
          end
        end
        else if (!s.scl_s)
        begin
          restart = 1'b1;
        end
        else if (ph_done)
        begin
          next_s.sda_drv = 1'b0;
          next_s.master  = 1'b0;
          next_s.step    = 1'b0;
          next_s.state   = smbus_pkg::ST_IDLE;
        end
      end
      smbus_pkg::ST_S_RX:
      begin
        if (rise && !s.bit_idx[3])
        begin
          next_s.shift = {s.shift[6:0], s.sda_s};
        end
        if (fall)
        begin
          if (s.bit_idx == 4'h7)
          begin
            next_s.scl_drv = 1'b1;
            next_s.state   = smbus_pkg::ST_S_ACK;
          end
          else
          begin
            next_s.bit_idx = s.bit_idx + 4'h1;
          end
        end
      end
      smbus_pkg::ST_S_ACK:
      begin
        if (s.addr_ph)
        begin
          ackv = !s.inh && (hw_ack_en_i ? s.shift[7:1] == own_addr_i : slave_ack_i);
        end
        else
        begin
          ackv = hw_ack_en_i || slave_ack_i;
        end
        if (s.addr_ph || !s.tl_v)
        begin
          next_s.sda_drv = ackv;
          next_s.scl_drv = 1'b0;
          next_s.ack     = ackv;
          next_s.bit_idx = 4'h8;
          next_s.ev_byte = !s.addr_ph;
          next_s.ev_addr = s.addr_ph && ackv;
          push_v         = !s.addr_ph && ackv;
          if (s.addr_ph)
          begin
            next_s.rw = s.shift[0];
          end
          next_s.state = smbus_pkg::ST_S_ACKB;
        end
      end
      smbus_pkg::ST_S_ACKB:
      begin
        if (fall)
        begin
          next_s.sda_drv = 1'b0;
          next_s.bit_idx = 4'h0;
          next_s.addr_ph = 1'b0;
          if (!s.ack)
          begin
            next_s.state = smbus_pkg::ST_S_IGN;
          end
          else if (s.rw)
          begin
            next_s.scl_drv = 1'b1;
            next_s.state   = smbus_pkg::ST_S_TXW;
          end
          else
          begin
            next_s.state = smbus_pkg::ST_S_RX;
          end
        end
      end
      smbus_pkg::ST_S_TX:
      begin
        if (rise && s.bit_idx[3])
        begin
          next_s.ack     = !s.sda_s;
          next_s.ev_byte = 1'b1;
        end
        if (fall)
        begin
          if (s.bit_idx[3])
          begin
            next_s.scl_drv = s.ack;
            next_s.state   = s.ack ? smbus_pkg::ST_S_TXW : smbus_pkg::ST_S_IGN;
          end
          else if (s.bit_idx == 4'h7)
          begin
            next_s.sda_drv = 1'b0;
            next_s.bit_idx = 4'h8;
          end
          else
          begin
            next_s.shift   = {s.shift[6:0], 1'b0};
            next_s.sda_drv = !s.shift[6];
            next_s.bit_idx = s.bit_idx + 4'h1;
          end
        end
      end
      smbus_pkg::ST_S_TXW:
      begin
        next_s.scl_drv = 1'b1;
        if (accept && cmd_op_i == smbus_pkg::OP_SLV_DATA)
        begin
          next_s.shift   = cmd_data_i;
          next_s.sda_drv = !cmd_data_i[7];
          next_s.bit_idx = 4'h0;
          next_s.scl_drv = 1'b0;
          next_s.state   = smbus_pkg::ST_S_TX;
        end
      end
      smbus_pkg::ST_S_IGN:
      begin
        next_s.scl_drv = 1'b0;
        next_s.sda_drv = 1'b0;
      end
    endcase

    // Another master's START or STOP steers the slave side.
    // The SCL fall that closes the START wraps the bit index to zero before the first bit.
    if (!s.master && start_det)
    begin
      next_s.ev_arb  = s.state == smbus_pkg::ST_WAIT_FREE;
      next_s.state   = smbus_pkg::ST_S_RX;
      next_s.bit_idx = 4'hf;
      next_s.addr_ph = 1'b1;
      next_s.inh     = slave_inhibit_i;
      next_s.scl_drv = 1'b0;
      next_s.sda_drv = 1'b0;
    end
    else if (!s.master && stop_det && s.state >= smbus_pkg::ST_S_RX)
    begin
      next_s.ev_stop = s.state != smbus_pkg::ST_S_IGN && !s.addr_ph;
      next_s.state   = smbus_pkg::ST_IDLE;
      next_s.scl_drv = 1'b0;
      next_s.sda_drv = 1'b0;
    end

    if (restart)
    begin
      next_s.ph_cnt   = 8'h00;
      next_s.tick_cnt = 2'h0;
    end

    // Two-entry receive buffer fill.
    if (push_v)
    begin
      if (!next_s.hd_v)
      begin
        next_s.hd_v = 1'b1;
        next_s.hd_d = push_d;
      end
      else
      begin
        next_s.tl_v = 1'b1;
        next_s.tl_d = push_d;
      end
    end

    if (!enable_i)
    begin
      next_s.state   = smbus_pkg::ST_IDLE;
      next_s.scl_drv = 1'b0;
      next_s.sda_drv = 1'b0;
      next_s.master  = 1'b0;
      next_s.step    = 1'b0;
    end

    // Every command waits for room in the buffer, so a full buffer stalls the command source.
    next_s.cmd_ready = enable_i && !next_s.tl_v &&
                       (next_s.state == smbus_pkg::ST_IDLE ||
                        next_s.state == smbus_pkg::ST_S_TXW ||
                        (next_s.state == smbus_pkg::ST_M_HOLD && next_s.step));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s <= '0;
      // Synchronisers wake at the idle level of the lines, so no false edge follows reset.
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_q <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_q <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  ////////////////////////////////////////////////////////////////////////////////

  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = s.scl_drv;
  assign sda_oe_o    = s.sda_drv;
  assign cmd_ready_o = s.cmd_ready;
  assign rx_valid_o  = s.hd_v;
  assign rx_data_o   = s.hd_d;
  assign byte_done_o = s.ev_byte;
  assign ack_o       = s.ack;
  assign arb_lost_o  = s.ev_arb;
  assign stop_seen_o = s.ev_stop;
  assign addressed_o = s.ev_addr;
  assign master_o    = s.master;
  assign busy_o      = s.busy;
  assign read_dir_o  = s.rw;

endmodule // smbus_if_core

/* File: rtl/smbus_pkg.sv */
// Purpose: Types of the two-wire bus interface.
// Assumes: Constants come from smbus_cfg.svh.
// Notes:   The whole state of the block is one packed struct.
package smbus_pkg;

  typedef enum logic [2:0] {
    OP_START,
    OP_WRITE,
    OP_READ,
    OP_STOP,
    OP_SLV_DATA
  } cmd_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_WAIT_FREE,
    ST_M_START,
    ST_M_LOW,
    ST_M_HIGH,
    ST_M_HOLD,
    ST_M_STOP,
    ST_S_RX,
    ST_S_ACK,
    ST_S_ACKB,
    ST_S_TX,
    ST_S_TXW,
    ST_S_IGN
  } st_t;

  typedef struct packed {
    st_t        state;
    logic       scl_m;
    logic       scl_s;
    logic       scl_q;
    logic       sda_m;
    logic       sda_s;
    logic       sda_q;
    logic       busy;
    logic [3:0] free_cnt;
    logic [7:0] ph_cnt;
    logic [1:0] tick_cnt;
    logic       step;
    logic [3:0] bit_idx;
    logic [7:0] shift;
    logic       samp;
    logic       rw;
    logic       addr_ph;
    logic       inh;
    logic       ack;
    logic       mack;
    logic       is_read;
    logic       scl_drv;
    logic       sda_drv;
    logic       master;
    logic       cmd_ready;
    logic       ev_byte;
    logic       ev_arb;
    logic       ev_stop;
    logic       ev_addr;
    logic       hd_v;
    logic [7:0] hd_d;
    logic       tl_v;
    logic [7:0] tl_d;
  } state_t;

endpackage

/* File: sim/smbus_if_core_props.sv */
// Purpose: Concurrent checks on the ports of the two-wire bus engine.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes:   Bound into every instance of smbus_if_core.
`timescale 1ns/1ns
module smbus_if_core_props (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       scl_o,
  input wire logic       sda_o,
  input wire logic       scl_oe_o,
  input wire logic       sda_oe_o,
  input wire logic       cmd_valid_i,
  input wire logic       cmd_ready_o,
  input wire logic       rx_valid_o,
  input wire logic       rx_ready_i,
  input wire logic [7:0] rx_data_o,
  input wire logic       master_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////////////////////////////////////////////////////
  sequence low_held;
    (scl_oe_o || !master_o) [*8];
  endsequence
  sequence high_held;
    (!scl_oe_o || !master_o) [*8];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  chk_od_zero: assert property (!scl_o && !sda_o)
    else $error("Line output value is not low");
  chk_low_phase: assert property ($rose(scl_oe_o) && master_o |=> low_held)
    else $error("SCL low phase too short");
  chk_high_phase: assert property ($fell(scl_oe_o) && master_o |=> high_held)
    else $error("SCL high phase too short");
  chk_sda_hold: assert property ($rose(scl_oe_o) && master_o |=> $stable(sda_oe_o) [*2])
    else $error("SDA changed too soon after SCL fell");
  chk_start_free: assert property ($rose(master_o) |-> !$past(busy_o))
    else $error("Master started on a busy bus");
  chk_stop_release: assert property ($fell(master_o) |-> !scl_oe_o && !sda_oe_o)
    else $error("Lines still driven after the transfer");
  chk_ready_drop: assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
    else $error("Command ready stayed high after acceptance");
  chk_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("Received word lost while stalled");
endmodule // smbus_if_core_props

bind smbus_if_core smbus_if_core_props u_props (
  .clk_i       (clk_i),
  .arst_n_i    (arst_n_i),
  .scl_o       (scl_o),
  .sda_o       (sda_o),
  .scl_oe_o    (scl_oe_o),
  .sda_oe_o    (sda_oe_o),
  .cmd_valid_i (cmd_valid_i),
  .cmd_ready_o (cmd_ready_o),
  .rx_valid_o  (rx_valid_o),
  .rx_ready_i  (rx_ready_i),
  .rx_data_o   (rx_data_o),
  .master_o    (master_o),
  .busy_o      (busy_o)
);

/* File: sim/smbus_slave_model.sv */
// Purpose: Behavioural slave on the shared two-wire bus.
// Assumes: Lines are pulled up; an enable high pulls its line low.
// Notes:   Read bytes are rd_byte_i plus the byte count in the frame.
`timescale 1ns/1ns
module smbus_slave_model #(
  parameter logic [6:0] ADDR = 7'h5a
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] rd_byte_i,
  output logic            scl_oe_o,
  output logic            sda_oe_o,
  output logic [7:0]      rx_byte_o
);
  logic [7:0] b;
  logic       more;
  initial
  begin
    scl_oe_o  = 1'b0;
    sda_oe_o  = 1'b0;
    rx_byte_o = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic get_byte();
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge scl_i);
      b[i] = sda_i;
    end
  endtask
  // A read keeps SDA after the ACK, so the first data bit is the only change then.
  task automatic give_ack(input logic rel);
    @(negedge scl_i);
    #20 sda_oe_o = 1'b1;
    if (slow_i)
    begin
      scl_oe_o = 1'b1;
      #400 scl_oe_o = 1'b0;
    end
    @(negedge scl_i);
    #20;
    if (rel)
      sda_oe_o = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always
  begin : serve
    @(negedge sda_i iff scl_i === 1'b1);
    get_byte();
    if (b[7:1] == ADDR)
    begin
      give_ack(!b[0]);
      if (b[0])
      begin
        more = 1'b1;
        for (int k = 0; more; k++)
        begin
          b = rd_byte_i + 8'(k);
          for (int i = 7; i >= 0; i--)
          begin
            sda_oe_o = !b[i];
            @(negedge scl_i);
            #20;
          end
          sda_oe_o = 1'b0;
          @(posedge scl_i);
          more = !sda_i;
          @(negedge scl_i);
          #20;
        end
      end
      else
        forever
        begin
          get_byte();
          rx_byte_o = b;
          give_ack(1'b1);
        end
    end
  end
  // A STOP ends whatever the slave was doing and frees both lines.
  always @(posedge sda_i)
    if (scl_i === 1'b1)
    begin
      disable serve;
      sda_oe_o = 1'b0;
      scl_oe_o = 1'b0;
    end
endmodule // smbus_slave_model

/* File: sim/two_wire_smbus_interface_test.sv */
// Purpose: Self-checking bench for the two-wire bus engine.
// Assumes: 100 MHz clock; the bench master runs a 125 ns link clock.
// Notes:   Wire levels are the inverse of the OR of all enables.
`timescale 1ns/1ns
module two_wire_smbus_interface_test;
  logic               clk_i = 1'b0;
  logic               arst_n_i = 1'b0;
  logic               bus_tick_i = 1'b0;
  logic               cmd_valid_i = 1'b0;
  logic               cmd_ack_i = 1'b0;
  logic               rx_ready_i = 1'b0;
  logic               slow = 1'b0;
  logic               bm_scl_oe = 1'b0;
  logic               bm_sda_oe = 1'b0;
  logic               seen_addr = 1'b0;
  logic               seen_stop = 1'b0;
  logic               seen_arb = 1'b0;
  logic [6:0]         own_addr = 7'h00;
  logic [7:0]         cmd_data_i = 8'h00;
  logic [7:0]         rd_byte = 8'h00;
  smbus_pkg::cmd_op_t cmd_op_i = smbus_pkg::OP_START;
  logic               d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe, cmd_ready_o, rx_valid_o;
  logic               byte_done_o, ack_o, addressed_o, master_o, stop_seen_o, read_dir_o;
  logic               arb_lost_o, busy_o;
  logic [7:0]         rx_data_o, m_rx;
  int                 fail_count = 0;
  int                 n_compared = 0;
  int                 cyc = 0;
  wire                scl = !(d_scl_oe | m_scl_oe | bm_scl_oe);
  wire                sda = !(d_sda_oe | m_sda_oe | bm_sda_oe);
  always #5 clk_i = !clk_i;
  always @(negedge clk_i) bus_tick_i <= !bus_tick_i;
  always @(posedge clk_i)
  begin
    seen_addr <= seen_addr | (addressed_o === 1'b1);
    seen_stop <= seen_stop | (stop_seen_o === 1'b1);
    seen_arb  <= seen_arb | (arb_lost_o === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      $display("MISMATCH at %0t: timeout", $time);
      end_sim();
    end
  end
  smbus_if_core u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda), .scl_o(), .sda_o(),
    .scl_oe_o(d_scl_oe), .sda_oe_o(d_sda_oe), .bus_tick_i(bus_tick_i), .enable_i(1'b1),
    .slave_inhibit_i(1'b0), .hw_ack_en_i(1'b1), .free_to_en_i(1'b1), .slave_ack_i(1'b1),
    .own_addr_i(own_addr), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_data_i(cmd_data_i), .cmd_ack_i(cmd_ack_i), .cmd_ready_o(cmd_ready_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
    .byte_done_o(byte_done_o), .ack_o(ack_o), .arb_lost_o(arb_lost_o),
    .stop_seen_o(stop_seen_o), .addressed_o(addressed_o), .master_o(master_o),
    .busy_o(busy_o), .read_dir_o(read_dir_o));
  smbus_slave_model u_slave (.scl_i(scl), .sda_i(sda), .slow_i(slow), .rd_byte_i(rd_byte),
    .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe), .rx_byte_o(m_rx));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input smbus_pkg::cmd_op_t op, input logic [7:0] d, input logic a);
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_op_i    = op;
    cmd_data_i  = d;
    cmd_ack_i   = a;
    while (cmd_ready_o !== 1'b1)
      @(negedge clk_i);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    if (op == smbus_pkg::OP_STOP)
      wait (master_o === 1'b0);
    else
      wait (byte_done_o === 1'b1);
    @(negedge clk_i);
  endtask
  task automatic pop(input logic [7:0] exp);
    chk(rx_valid_o, 8'h01, "rx valid");
    chk(rx_data_o, exp, "rx data");
    rx_ready_i = 1'b1;
    @(negedge clk_i);
    rx_ready_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic bm_byte(input logic [8:0] v, output logic g);
    for (int i = 8; i >= 0; i--)
    begin
      #31 bm_sda_oe = !v[i];
      #31 bm_scl_oe = 1'b0;
      wait (scl === 1'b1);
      #31 g = sda;
      #32 bm_scl_oe = 1'b1;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_write();
    slow = 1'b1;
    cmd(smbus_pkg::OP_START, {7'h5a, 1'b0}, 1'b0);
    chk(master_o, 8'h01, "master after start");
    chk(busy_o, 8'h01, "busy during transfer");
    chk(ack_o, 8'h01, "address ack");
    cmd(smbus_pkg::OP_WRITE, 8'ha5, 1'b0);
    chk(m_rx, 8'ha5, "byte at slave");
    chk(ack_o, 8'h01, "data ack");
    cmd(smbus_pkg::OP_STOP, 8'h00, 1'b0);
    chk({scl, sda}, 8'h03, "idle lines");
    slow = 1'b0;
  endtask
  task automatic t_read();
    rd_byte = 8'h3c;
    cmd(smbus_pkg::OP_START, {7'h5a, 1'b1}, 1'b0);
    cmd(smbus_pkg::OP_READ, 8'h00, 1'b1);
    cmd(smbus_pkg::OP_READ, 8'h00, 1'b0);
    chk(ack_o, 8'h00, "nack sent");
    repeat (40) @(negedge clk_i);
    chk(cmd_ready_o, 8'h00, "ready with full buffer");
    pop(8'h3c);
    pop(8'h3d);
    chk(rx_valid_o, 8'h00, "buffer empty");
    cmd(smbus_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic t_nack();
    cmd(smbus_pkg::OP_START, {7'h33, 1'b0}, 1'b0);
    chk(ack_o, 8'h00, "address nack");
    cmd(smbus_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic t_slave_rx();
    logic g;
    @(negedge clk_i);
    own_addr = 7'h21;
    #33 bm_sda_oe = 1'b1;
    #63 bm_scl_oe = 1'b1;
    bm_byte({7'h21, 1'b0, 1'b1}, g);
    chk(g, 8'h00, "slave address ack");
    bm_byte({8'h96, 1'b1}, g);
    chk(g, 8'h00, "slave data ack");
    #31 bm_sda_oe = 1'b1;
    #31 bm_scl_oe = 1'b0;
    #63 bm_sda_oe = 1'b0;
    repeat (10) @(negedge clk_i);
    pop(8'h96);
    chk(seen_addr, 8'h01, "addressed event");
    chk(read_dir_o, 8'h00, "write direction");
    chk(seen_stop, 8'h01, "stop event");
    chk(busy_o, 8'h00, "bus free after stop");
    chk(seen_arb, 8'h00, "no lost arbitration");
  endtask
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    t_write();
    t_read();
    t_nack();
    t_slave_rx();
    end_sim();
  end
endmodule // two_wire_smbus_interface_test
